// ---- core/vcr_timing.v ----
// character-row video timing generator with its code buffer
`include "vcr_defs.vh"

// ****************************************************************
// code buffer: flags come from flops so the top stays registered
// ****************************************************************
module vcr_fifo #(
    parameter WIDTH = `VCR_FIFO_WIDTH,
    parameter DEPTH = `VCR_FIFO_DEPTH,
    parameter AW = `VCR_FIFO_AW
) (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // fill side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output reg in_ready_reg,
    // drain side
    output reg out_valid_reg,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg [AW:0] count_next;
    wire push;
    wire pop;
    assign push = in_valid & in_ready_reg;
    assign pop = out_valid_reg & out_ready;
    assign out_data = mem[rd_ptr_reg];
    // occupancy after this edge
    always @* begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop & ~push) begin
            count_next = count_reg - 1'b1;
        end
    end
    // storage has no reset; only pointers matter
    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
    // pointers and flags
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            in_ready_reg <= 1'b0;
            out_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready_reg <= (count_next != DEPTH[AW:0]);
            out_valid_reg <= (count_next != {(AW+1){1'b0}});
        end
    end
endmodule

// ****************************************************************
// timing generator top
// ****************************************************************
module vcr_timing (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // bus side pins
    input wire display_ram_select,
    input wire sync_not_phase2,
    input wire access_end,
    input wire [5:0] bus_addr,
    // character codes from the display ram latch
    input wire code_valid,
    input wire [6:0] code_data,
    output wire code_ready,
    // dot patterns toward the video shifter
    output reg pix_valid_reg,
    output reg [8:0] pix_data_reg,
    input wire pix_ready,
    // timing outputs
    output reg char_clock_reg,
    output reg line_advance_pulse_reg,
    output reg horiz_display_window_reg,
    output reg vert_display_flag_reg,
    output reg row_complete_reg,
    output reg [3:0] scan_line_reg,
    output reg [3:0] text_row_reg,
    output reg [5:0] ram_addr_reg,
    output reg bus_owns_addr_reg
);
    // glyph lookup; only a few shapes are tabled here
    function [8:0] vcr_glyph;
        input [6:0] code;
        input [3:0] line;
        begin
            vcr_glyph = 9'h000;
            if (line == `VCR_SCAN_BLANK) begin
                vcr_glyph = 9'h000;
            end else if (code == 7'h49) begin
                case (line)
                    4'h0, 4'h8: vcr_glyph = 9'h0F8;
                    4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                    4'h7: vcr_glyph = 9'h020;
                    default: vcr_glyph = 9'h000;
                endcase
            end else if (code == 7'h70) begin
                case (line)
                    4'h3, 4'h8: vcr_glyph = 9'h170;
                    4'h4, 4'h7: vcr_glyph = 9'h188;
                    4'h5, 4'h6: vcr_glyph = 9'h108;
                    4'h9, 4'hA, 4'hB: vcr_glyph = 9'h100;
                    default: vcr_glyph = 9'h000;
                endcase
            end else if (code[6:5] != 2'b00 && line < 4'h9) begin
                // untabled printable codes show as a hollow box
                if (line == 4'h0 || line == 4'h8) begin
                    vcr_glyph = 9'h1F0;
                end else begin
                    vcr_glyph = 9'h110;
                end
            end
        end
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    reg sel_meta_reg;
    reg sel_sync_reg;
    reg snp_meta_reg;
    reg snp_sync_reg;
    reg snp_prev_reg;
    reg end_meta_reg;
    reg end_sync_reg;
    reg [5:0] addr_meta_reg;
    reg [5:0] addr_sync_reg;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sel_meta_reg <= 1'b0;
            sel_sync_reg <= 1'b0;
            snp_meta_reg <= 1'b0;
            snp_sync_reg <= 1'b0;
            snp_prev_reg <= 1'b0;
            end_meta_reg <= 1'b0;
            end_sync_reg <= 1'b0;
            addr_meta_reg <= 6'h00;
            addr_sync_reg <= 6'h00;
        end else begin
            sel_meta_reg <= display_ram_select;
            sel_sync_reg <= sel_meta_reg;
            snp_meta_reg <= sync_not_phase2;
            snp_sync_reg <= snp_meta_reg;
            snp_prev_reg <= snp_sync_reg;
            end_meta_reg <= access_end;
            end_sync_reg <= end_meta_reg;
            addr_meta_reg <= bus_addr;
            addr_sync_reg <= addr_meta_reg;
        end
    end

    // ************************************************************
    // dot to character clock division
    // ************************************************************
    reg [3:0] dot_cnt_reg;
    wire char_tick;

    // preset 7 then count to 15: nine dots a character
    assign char_tick = (dot_cnt_reg == `VCR_DOT_LAST);
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dot_cnt_reg <= `VCR_DOT_PRESET;
            char_clock_reg <= 1'b0;
        end else begin
            if (char_tick) begin
                dot_cnt_reg <= `VCR_DOT_PRESET;
            end else begin
                dot_cnt_reg <= dot_cnt_reg + 1'b1;
            end
            // high five dots, low four
            char_clock_reg <= (dot_cnt_reg >= `VCR_CCLK_FROM);
        end
    end

    // ************************************************************
    // horizontal position counters
    // ************************************************************
    reg [3:0] low_cnt_reg;
    reg [3:0] grp_cnt_reg;
    reg [3:0] low_next;
    reg [3:0] grp_next;
    wire line_load;
    wire line_end;

    assign line_load = (grp_cnt_reg == `VCR_GRP_END) &&
        (low_cnt_reg == `VCR_LOW_END);
    assign line_end = char_tick & line_load;

    // next counter values, stepped only on the character tick
    always @* begin
        low_next = low_cnt_reg;
        grp_next = grp_cnt_reg;
        if (char_tick) begin
            if (line_load) begin
                low_next = `VCR_HV_PRESET;
                grp_next = `VCR_HV_PRESET;
            end else begin
                low_next = low_cnt_reg + 1'b1;
                if (low_cnt_reg == `VCR_LOW_LAST) begin
                    grp_next = grp_cnt_reg + 1'b1;
                end
            end
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            low_cnt_reg <= `VCR_HV_PRESET;
            grp_cnt_reg <= `VCR_HV_PRESET;
            line_advance_pulse_reg <= 1'b0;
            horiz_display_window_reg <= 1'b0;
        end else begin
            low_cnt_reg <= low_next;
            grp_cnt_reg <= grp_next;
            line_advance_pulse_reg <= grp_next[`VCR_ADV_BIT];
            horiz_display_window_reg <= grp_next[`VCR_HORIZ_DISPLAY_WINDOW_BIT];
        end
    end

    // ************************************************************
    // display ram low address multiplexer
    // ************************************************************
    wire take_bus;
    // a mid-sync rise while the ram is selected claims the address
    assign take_bus = sel_sync_reg & snp_sync_reg & ~snp_prev_reg;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bus_owns_addr_reg <= 1'b0;
            ram_addr_reg <= 6'h00;
        end else begin
            // set beats clear so a claim at cycle end is kept
            if (take_bus) begin
                bus_owns_addr_reg <= 1'b1;
            end else if (end_sync_reg) begin
                bus_owns_addr_reg <= 1'b0;
            end
            if (bus_owns_addr_reg) begin
                ram_addr_reg <= addr_sync_reg;
            end else begin
                ram_addr_reg <= {grp_next[1:0], low_next};
            end
        end
    end

    // ************************************************************
    // scan line and text row counters
    // ************************************************************
    wire row_last;
    wire row_carry;
    wire vert_display_flag_next;

    assign row_last = (scan_line_reg == `VCR_SCAN_LAST) & line_end;
    assign row_carry = row_last &
        (text_row_reg == `VCR_TEXT_LAST);
    // reload value follows the flag as it stands after the toggle
    assign vert_display_flag_next = vert_display_flag_reg ^ row_carry;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scan_line_reg <= `VCR_SCAN_BLANK;
            text_row_reg <= `VCR_TEXT_ACTIVE;
            vert_display_flag_reg <= 1'b0;
            row_complete_reg <= 1'b0;
        end else begin
            row_complete_reg <= row_last;
            vert_display_flag_reg <= vert_display_flag_next;
            if (row_last) begin
                scan_line_reg <= `VCR_SCAN_BLANK;
            end else if (line_end) begin
                scan_line_reg <= scan_line_reg + 1'b1;
            end
            if (row_carry) begin
                text_row_reg <= vert_display_flag_next ? `VCR_TEXT_BLANK :
                    `VCR_TEXT_ACTIVE;
            end else if (row_last) begin
                text_row_reg <= text_row_reg + 1'b1;
            end
        end
    end

    // ************************************************************
    // character stream and glyph lookup
    // ************************************************************
    wire buf_valid;
    wire [6:0] buf_data;
    wire buf_take;
    // the shifter stalling leaves codes in the buffer until it fills
    assign buf_take = ~pix_valid_reg | pix_ready;

    vcr_fifo #(
        .WIDTH(`VCR_FIFO_WIDTH),
        .DEPTH(`VCR_FIFO_DEPTH),
        .AW(`VCR_FIFO_AW)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(code_valid),
        .in_data(code_data),
        .in_ready_reg(code_ready),
        .out_valid_reg(buf_valid),
        .out_data(buf_data),
        .out_ready(buf_take)
    );

    // pattern uses the scan line current when the code is taken
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pix_valid_reg <= 1'b0;
            pix_data_reg <= 9'h000;
        end else if (buf_take) begin
            pix_valid_reg <= buf_valid;
            if (buf_valid) begin
                pix_data_reg <= vcr_glyph(buf_data, scan_line_reg);
            end
        end
    end
endmodule

// ---- dv/tb_vcr_timing.sv ----
// self-checking bench for the character-row timing generator
`define CHK(n, e, a) begin \
    samples_checked++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("BAD %s exp %0h got %0h", n, e, a); \
    end \
end

module tb_vcr_timing;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic code_valid, stall, go, pix_ready;
    logic [6:0] code_data;
    logic [5:0] go_addr, bus_addr, ram_addr_reg;
    logic display_ram_select, sync_not_phase2, access_end, code_ready;
    logic pix_valid_reg, vert_display_flag_reg, row_complete_reg;
    logic line_advance_pulse_reg, horiz_display_window_reg;
    logic bus_owns_addr_reg;
    logic [8:0] pix_data_reg;
    logic [3:0] scan_line_reg, text_row_reg;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;

    vcr_timing uut (.ref_clk, .reset, .display_ram_select,
        .sync_not_phase2, .access_end, .bus_addr, .code_valid, .code_data,
        .code_ready, .pix_valid_reg, .pix_data_reg, .pix_ready,
        .char_clock_reg(), .line_advance_pulse_reg,
        .horiz_display_window_reg, .vert_display_flag_reg,
        .row_complete_reg, .scan_line_reg, .text_row_reg, .ram_addr_reg,
        .bus_owns_addr_reg);
    vcr_far_side u_far (.ref_clk, .reset, .stall, .go, .go_addr,
        .pix_ready, .display_ram_select, .sync_not_phase2, .access_end,
        .bus_addr);

    // 100 ns clock
    initial forever #50 ref_clk = ~ref_clk;

    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard: the whole run needs about 36000 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            summarize();
        end
    end

    // expected dots for the two fully known glyphs
    function automatic logic [8:0] glyph(input logic [6:0] c,
                                         input logic [3:0] l);
        if (l > 4'hB)
            return 9'h000;
        if (c == 7'h49)
            return (l == 0 || l == 8) ? 9'h0F8 : (l < 8 ? 9'h020 : 9'h000);
        case (l)
            3, 8: return 9'h170;
            4, 7: return 9'h188;
            5, 6: return 9'h108;
            default: return (l > 8) ? 9'h100 : 9'h000;
        endcase
    endfunction

    task automatic t_reset;
        `CHK("rst scan", 4'hF, scan_line_reg)
        `CHK("rst text", 4'h0, text_row_reg)
        `CHK("rst flag", 1'b0, vert_display_flag_reg)
        `CHK("rst ready", 1'b0, code_ready)
    endtask

    task automatic t_line;
        int n, w, a;
        logic p;
        n = 0;
        do begin
            p = line_advance_pulse_reg;
            @(posedge ref_clk);
            n++;
        end while (!(p && !line_advance_pulse_reg) && n < 1000);
        n = 0;
        w = 0;
        a = 0;
        do begin
            p = line_advance_pulse_reg;
            @(posedge ref_clk);
            n++;
            w += horiz_display_window_reg;
            a += line_advance_pulse_reg;
            if (n == 3)
                `CHK("reload addr", 6'h33, ram_addr_reg)
        end while (!(p && !line_advance_pulse_reg) && n < 1000);
        `CHK("line len", 918, n)
        `CHK("window len", 576, w)
        `CHK("advance len", 225, a)
    endtask

    task automatic t_bus;
        int n;
        go <= 1'b1;
        go_addr <= 6'h2A;
        @(posedge ref_clk);
        go <= 1'b0;
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            if (bus_owns_addr_reg === 1'b1)
                n++;
            if (n == 2)
                `CHK("bus addr", 6'h2A, ram_addr_reg)
        end
        `CHK("bus span", 11, n)
    endtask

    task automatic look(input logic [6:0] c);
        int n;
        n = 0;
        code_valid <= 1'b1;
        code_data <= c;
        do begin
            @(posedge ref_clk);
            n++;
        end while (code_ready !== 1'b1 && n < 50);
        code_valid <= 1'b0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pix_valid_reg !== 1'b1 && n < 100);
        `CHK("glyph", glyph(c, scan_line_reg), pix_data_reg)
    endtask

    task automatic t_glyph;
        logic [3:0] s;
        int n;
        for (int i = 0; i < 13; i++) begin
            s = scan_line_reg;
            n = 0;
            while (scan_line_reg === s && n < 1000) begin
                @(posedge ref_clk);
                n++;
            end
            look(7'h49);
            look(7'h70);
        end
    endtask

    // sink stalls while the buffer fills, then drains it
    task automatic t_fifo;
        int n, m;
        n = 0;
        m = 0;
        stall <= 1'b1;
        repeat (3) @(posedge ref_clk);
        code_valid <= 1'b1;
        code_data <= 7'h00;
        repeat (40) begin
            @(posedge ref_clk);
            if (code_ready === 1'b1)
                n++;
        end
        code_valid <= 1'b0;
        `CHK("full", 1'b0, code_ready)
        `CHK("fill", 1'b1, (n >= 32 && n <= 34))
        stall <= 1'b0;
        repeat (60) begin
            @(posedge ref_clk);
            if (pix_valid_reg === 1'b1 && pix_ready === 1'b1)
                m++;
        end
        `CHK("drain", n, m)
        `CHK("ready again", 1'b1, code_ready)
    endtask

    task automatic t_rows;
        int n;
        logic [3:0] t;
        n = 0;
        while (row_complete_reg !== 1'b1 && n < 13000) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK("row scan", 4'hF, scan_line_reg)
        t = text_row_reg;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (row_complete_reg !== 1'b1 && n < 13000);
        `CHK("row len", 11934, n)
        `CHK("row step", t + 4'h1, text_row_reg)
    endtask

    initial begin
        code_valid = 1'b0;
        code_data = 7'h00;
        stall = 1'b0;
        go = 1'b0;
        go_addr = 6'h00;
        repeat (12) @(posedge ref_clk);
        t_reset();
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_line();
        t_bus();
        t_glyph();
        t_fifo();
        t_rows();
        summarize();
    end
endmodule

// ---- dv/vcr_far_side.sv ----
// far-side model: pattern sink and bus master reaching the display ram
module vcr_far_side (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // commands from the bench
    input wire logic stall,
    input wire logic go,
    input wire logic [5:0] go_addr,
    // pins toward the timing block
    output logic pix_ready,
    output logic display_ram_select,
    output logic sync_not_phase2,
    output logic access_end,
    output logic [5:0] bus_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    int phase;
    // one access: select, mid-sync rise, end of cycle, then release
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pix_ready <= 1'b0;
            display_ram_select <= 1'b0;
            sync_not_phase2 <= 1'b0;
            access_end <= 1'b0;
            bus_addr <= 6'h00;
            phase <= 0;
        end else begin
            pix_ready <= !stall;
            if (phase == 0 && go) begin
                display_ram_select <= 1'b1;
                bus_addr <= go_addr;
                phase <= 1;
            end else if (phase != 0) begin
                phase <= phase + 1;
                if (phase == 1)
                    sync_not_phase2 <= 1'b1;
                if (phase == 12)
                    access_end <= 1'b1;
                // released lines must not keep the last value
                if (phase == 18) begin
                    display_ram_select <= 1'b0;
                    sync_not_phase2 <= 1'b0;
                    access_end <= 1'b0;
                    bus_addr <= ~bus_addr;
                    phase <= 0;
                end
            end
        end
    end
endmodule

// ---- dv/vcr_timing_props.sv ----
// assertion checker for the character-row timing generator
module vcr_timing_props (
    // clock and reset
    input wire ref_clk,
    input wire reset,
    // bus pins
    input wire display_ram_select,
    input wire sync_not_phase2,
    // pattern stream
    input wire pix_valid_reg,
    input wire [8:0] pix_data_reg,
    input wire pix_ready,
    // timing outputs
    input wire char_clock_reg,
    input wire line_advance_pulse_reg,
    input wire horiz_display_window_reg,
    input wire vert_display_flag_reg,
    input wire row_complete_reg,
    input wire [3:0] scan_line_reg,
    input wire [3:0] text_row_reg,
    input wire [5:0] ram_addr_reg,
    input wire bus_owns_addr_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    int pcnt;
    int hcnt;
    int wcnt;
    logic seen;
    // span counters: a line is far too long for a repetition operator
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pcnt <= 0;
            hcnt <= 0;
            wcnt <= 0;
            seen <= 1'b0;
        end else begin
            pcnt <= $fell(line_advance_pulse_reg) ? 0 : pcnt + 1;
            hcnt <= line_advance_pulse_reg ? hcnt + 1 : 0;
            wcnt <= horiz_display_window_reg ? wcnt + 1 : 0;
            seen <= seen | $fell(line_advance_pulse_reg);
        end
    end
    a_line_period: assert property (
        $fell(line_advance_pulse_reg) && seen |-> pcnt == 917)
        else $error("line period wrong");
    a_advance_span: assert property (
        $fell(line_advance_pulse_reg) |-> hcnt == 225)
        else $error("advance span wrong");
    a_window_span: assert property (
        $fell(horiz_display_window_reg) |-> wcnt == 576
        ##0 line_advance_pulse_reg) else $error("window span wrong");
    a_refresh_step: assert property (
        $changed(ram_addr_reg) && seen && !bus_owns_addr_reg
        && !$past(bus_owns_addr_reg) && !$past(bus_owns_addr_reg, 2)
        |-> ram_addr_reg == $past(ram_addr_reg) + 6'h01
        || ($past(ram_addr_reg) == 6'h18 && ram_addr_reg == 6'h33))
        else $error("refresh address step wrong");
    a_scan_order: assert property (
        $changed(scan_line_reg) |-> scan_line_reg == $past(scan_line_reg)
        + 4'h1 || ($past(scan_line_reg) == 4'hB && scan_line_reg == 4'hF))
        else $error("scan order wrong");
    a_scan_per_line: assert property (
        $changed(scan_line_reg) |-> !line_advance_pulse_reg
        && $past(line_advance_pulse_reg, 2)) else $error("scan step off");
    a_row_pulse: assert property (
        row_complete_reg |-> scan_line_reg == 4'hF ##1 !row_complete_reg)
        else $error("row pulse wrong");
    a_row_after_last: assert property (
        scan_line_reg == 4'hF && $past(scan_line_reg) == 4'hB
        |-> ##[0:2] row_complete_reg) else $error("row pulse missing");
    a_text_reload: assert property (
        $changed(text_row_reg) |-> text_row_reg == $past(text_row_reg)
        + 4'h1 || ($past(text_row_reg) == 4'hF && text_row_reg
        == (vert_display_flag_reg ? 4'hC : 4'h0)))
        else $error("text row step wrong");
    a_flag_on_carry: assert property (
        $changed(vert_display_flag_reg) |-> $past(text_row_reg) == 4'hF)
        else $error("flag toggled off carry");
    a_bus_take: assert property (
        $rose(bus_owns_addr_reg) |-> $past(display_ram_select, 2)
        && $past(sync_not_phase2, 2)) else $error("bus take unprompted");
    a_pix_hold: assert property (
        pix_valid_reg && !pix_ready |=> pix_valid_reg
        && $stable(pix_data_reg)) else $error("pattern not held");
    a_char_clock_shape: assert property (
        $rose(char_clock_reg) |-> char_clock_reg [*5] ##1
        !char_clock_reg [*4] ##1 char_clock_reg)
        else $error("char clock shape wrong");
endmodule

bind vcr_timing vcr_timing_props u_props (
    .ref_clk, .reset, .display_ram_select, .sync_not_phase2,
    .pix_valid_reg, .pix_data_reg, .pix_ready, .line_advance_pulse_reg,
    .horiz_display_window_reg, .vert_display_flag_reg, .row_complete_reg,
    .scan_line_reg, .text_row_reg, .ram_addr_reg, .bus_owns_addr_reg,
    .char_clock_reg
);

// ---- pkg/vcr_defs.vh ----
// constants for the character-row video timing generator
// What this block does
// - each scan line starts with both horizontal counters loaded to 3.
// - the low counter runs 3..15 first, then 0..15, bumping the group.
// - group 9 with low 8 makes the load that restarts the line at 3.
// - one line lasts 102 character clocks: 13, five times 16, then 9.
// - group bit 3 is the line advance, group bit 2 the display window.
// - refresh address bits 5..0 are group bits 1..0 and the low counter.
// - bus address takes over on ram select and mid-sync until cycle end.
// - the scan counter steps once a line and reads 15 on a row's first.
// - after 15 it counts 0..11, and at 11 it is loaded back to 15.
// - the glyph table gives a blank pattern for line address 15.
// - the glyph table takes the 7-bit code and line, gives nine dots.
// - one row-complete pulse per row steps the text row counter.
// - the row counter reloads on carry: 0 if flag low, 12 if high.
// - the character clock is the dot clock divided by nine.
// - the vertical flag toggles on each row carry: 16 shown, 4 blank.
`ifndef VCR_DEFS_VH
`define VCR_DEFS_VH

// ****************************************************************
// clock division
// ****************************************************************
`define VCR_DOT_PRESET 4'h7
`define VCR_DOT_LAST 4'hF
`define VCR_CCLK_FROM 4'hB
`define VCR_DOTS_PER_CHAR 9

// ****************************************************************
// horizontal counters
// ****************************************************************
`define VCR_HV_PRESET 4'h3
`define VCR_LOW_LAST 4'hF
`define VCR_GRP_END 4'h9
`define VCR_LOW_END 4'h8
`define VCR_ADV_BIT 3
`define VCR_HORIZ_DISPLAY_WINDOW_BIT 2
`define VCR_LINE_CHARS 102

// ****************************************************************
// scan and text row counters
// ****************************************************************
`define VCR_SCAN_BLANK 4'hF
`define VCR_SCAN_LAST 4'hB
`define VCR_TEXT_ACTIVE 4'h0
`define VCR_TEXT_BLANK 4'hC
`define VCR_TEXT_LAST 4'hF

// ****************************************************************
// character stream buffer
// ****************************************************************
`define VCR_FIFO_WIDTH 7
`define VCR_FIFO_DEPTH 32
`define VCR_FIFO_AW 5

`endif
